// file: hw/ccr_map.vh
// register indices, field positions, codes and reset values of the comparator control bank
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// register indices; the Avalon byte address is four times the index
`define CCR_IDX_DAC 8'h31
`define CCR_IDX_BUS_CFG 8'h61
`define CCR_IDX_RD_CLR 8'h78
`define CCR_IDX_IN_SEL 8'h79
`define CCR_IDX_ENABLE 8'h7A
`define CCR_IDX_IRQ_STAT 8'h80
`define CCR_IDX_IRQ_MASK 8'h81

// current dac code register
`define CCR_DAC_MSB 6
`define CCR_RST_DAC 7'h00

// analog bus configuration register
`define CCR_OVR_BIT 5
`define CCR_CAP_MSB 1
`define CCR_CAP_LSB 0
`define CCR_RST_OVR 1'h0
`define CCR_RST_CAP 2'h0

// comparator read and clear register
`define CCR_LIVE1_BIT 5
`define CCR_LIVE0_BIT 4
`define CCR_LATCH1_BIT 1
`define CCR_LATCH0_BIT 0
`define CCR_RST_LATCH 1'h0

// comparator input select register
`define CCR_P1_MSB 7
`define CCR_P1_LSB 6
`define CCR_N1_MSB 5
`define CCR_N1_LSB 4
`define CCR_P0_MSB 3
`define CCR_P0_LSB 2
`define CCR_N0_MSB 1
`define CCR_N0_LSB 0
`define CCR_RST_IN_SEL 8'h00
`define CCR_POS_BUS 2'h0
`define CCR_POS_PIN_FIRST 2'h2
`define CCR_POS_PIN_SECOND 2'h3
`define CCR_NEG_VREF 2'h0
`define CCR_NEG_LO 2'h1
`define CCR_NEG_HI 2'h2

// comparator enable register
`define CCR_EN1_BIT 4
`define CCR_EN0_BIT 0
`define CCR_RST_EN 1'h0

// interrupt status and mask: bit 0 latch 0 set, bit 1 latch 1 set
`define CCR_IRQ_W 2
`define CCR_RST_IRQ 2'h0

`endif

// file: hw/ccr_regs.v
// comparator, current dac and analog bus control register bank with Avalon-MM slave
`include "ccr_map.vh"

// Overview of operation
// - seven-bit current dac code, reset zero, driven to the current dac
// - override bit 5 lets sense clock run regardless of counter enable
// - capacitor select: none, first pin, second pin, both pins
// - status bits 5 and 4 show live comparator outputs, zero when disabled
// - bit 1 shows latch 1; cleared by zero write or latch reset source
// - bit 0 shows latch 0; cleared by zero write or latch reset source
// - positive select: 00 bus, 10 first pin, 11 second pin, 01 reserved
// - negative select: 00 fixed ref, 01 low ref, 10 high ref, 11 reserved
// - enable bits 4 and 0 power comparators 1 and 0, reset zero
// - reset source 0 means zero write, 1 means other logic output rising
module ccr_regs (
  input wire sys_clk,
  input wire reset,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire comp0_raw,
  input wire comp1_raw,
  input wire comp0_logic_function_output,
  input wire comp1_logic_function_output,
  input wire comp0_latch_reset_source,
  input wire comp1_latch_reset_source,
  input wire sense_counter_enable,
  output reg [6:0] current_dac_value,
  output reg sense_clock_run,
  output reg cap_pin_first_en,
  output reg cap_pin_second_en,
  output reg comp0_pos_bus,
  output reg comp0_pos_pin_first,
  output reg comp0_pos_pin_second,
  output reg comp0_neg_vref,
  output reg comp0_neg_lo,
  output reg comp0_neg_hi,
  output reg comp1_pos_bus,
  output reg comp1_pos_pin_first,
  output reg comp1_pos_pin_second,
  output reg comp1_neg_vref,
  output reg comp1_neg_lo,
  output reg comp1_neg_hi,
  output reg comp0_power_enable,
  output reg comp1_power_enable,
  output reg comp0_latch_state,
  output reg comp1_latch_state,
  output reg irq
);

  // one-hot {second pin, first pin, bus}; reserved code selects nothing
  function [2:0] pos_dec;
    input [1:0] code;
    begin
      case (code)
        `CCR_POS_BUS: pos_dec = 3'h1;
        `CCR_POS_PIN_FIRST: pos_dec = 3'h2;
        `CCR_POS_PIN_SECOND: pos_dec = 3'h4;
        default: pos_dec = 3'h0;
      endcase
    end
  endfunction

  // one-hot {high, low, fixed}; reserved code selects nothing
  function [2:0] neg_dec;
    input [1:0] code;
    begin
      case (code)
        `CCR_NEG_VREF: neg_dec = 3'h1;
        `CCR_NEG_LO: neg_dec = 3'h2;
        `CCR_NEG_HI: neg_dec = 3'h4;
        default: neg_dec = 3'h0;
      endcase
    end
  endfunction

  // write strobe for one register index, low byte lane only
  function wr_hit;
    input commit;
    input [7:0] idx;
    input [7:0] target;
    begin
      wr_hit = commit && (idx == target);
    end
  endfunction

  reg prox_override_q;
  reg [1:0] cap_sel_q;
  reg [7:0] in_sel_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg c0_s1_q;
  reg c0_s2_q;
  reg c1_s1_q;
  reg c1_s2_q;
  reg lf0_s1_q;
  reg lf0_s2_q;
  reg lf0_prev_q;
  reg lf1_s1_q;
  reg lf1_s2_q;
  reg lf1_prev_q;
  reg [7:0] rd_byte;
  reg latch0_d;
  reg latch1_d;
  reg [1:0] irq_stat_d;

  wire [7:0] idx = avs_address[9:2];
  wire req = avs_read | avs_write;
  // a write lands only at the edge where the master sees waitrequest low
  wire commit = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_dac = wr_hit(commit, idx, `CCR_IDX_DAC);
  wire wr_bus_cfg = wr_hit(commit, idx, `CCR_IDX_BUS_CFG);
  wire wr_rd_clr = wr_hit(commit, idx, `CCR_IDX_RD_CLR);
  wire wr_in_sel = wr_hit(commit, idx, `CCR_IDX_IN_SEL);
  wire wr_enable = wr_hit(commit, idx, `CCR_IDX_ENABLE);
  wire wr_irq_stat = wr_hit(commit, idx, `CCR_IDX_IRQ_STAT);
  wire wr_irq_mask = wr_hit(commit, idx, `CCR_IDX_IRQ_MASK);

  wire live0 = comp0_power_enable & c0_s2_q;
  wire live1 = comp1_power_enable & c1_s2_q;
  // edges are taken after the second stage, so a metastable first stage never feeds them
  wire lf0_rise = lf0_s2_q & ~lf0_prev_q;
  wire lf1_rise = lf1_s2_q & ~lf1_prev_q;
  wire [2:0] p0_oh = pos_dec(in_sel_q[`CCR_P0_MSB:`CCR_P0_LSB]);
  wire [2:0] n0_oh = neg_dec(in_sel_q[`CCR_N0_MSB:`CCR_N0_LSB]);
  wire [2:0] p1_oh = pos_dec(in_sel_q[`CCR_P1_MSB:`CCR_P1_LSB]);
  wire [2:0] n1_oh = neg_dec(in_sel_q[`CCR_N1_MSB:`CCR_N1_LSB]);

  // analog comparator and logic outputs are asynchronous to sys_clk
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      c0_s1_q <= 1'h0;
      c0_s2_q <= 1'h0;
      c1_s1_q <= 1'h0;
      c1_s2_q <= 1'h0;
      lf0_s1_q <= 1'h0;
      lf0_s2_q <= 1'h0;
      lf0_prev_q <= 1'h0;
      lf1_s1_q <= 1'h0;
      lf1_s2_q <= 1'h0;
      lf1_prev_q <= 1'h0;
    end
    else
    begin
      c0_s1_q <= comp0_raw;
      c0_s2_q <= c0_s1_q;
      c1_s1_q <= comp1_raw;
      c1_s2_q <= c1_s1_q;
      lf0_s1_q <= comp0_logic_function_output;
      lf0_s2_q <= lf0_s1_q;
      lf0_prev_q <= lf0_s2_q;
      lf1_s1_q <= comp1_logic_function_output;
      lf1_s2_q <= lf1_s1_q;
      lf1_prev_q <= lf1_s2_q;
    end
  end

  // latch next state: set wins over any clear in the same cycle
  always @*
  begin
    latch0_d = comp0_latch_state;
    latch1_d = comp1_latch_state;
    if (comp0_latch_reset_source)
    begin
      if (lf1_rise)
        latch0_d = 1'h0;
    end
    else if (wr_rd_clr && !wbyte[`CCR_LATCH0_BIT])
    begin
      latch0_d = 1'h0;
    end
    if (comp1_latch_reset_source)
    begin
      if (lf0_rise)
        latch1_d = 1'h0;
    end
    else if (wr_rd_clr && !wbyte[`CCR_LATCH1_BIT])
    begin
      latch1_d = 1'h0;
    end
    // an enabled comparator held high keeps its latch set; a clear only sticks once it drops or is disabled
    if (live0)
      latch0_d = 1'h1;
    if (live1)
      latch1_d = 1'h1;
  end

  // sticky latch-set events, write one to clear, new event beats the clear
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_irq_stat)
      irq_stat_d = irq_stat_q & ~wbyte[1:0];
    irq_stat_d = irq_stat_d | {live1 & ~comp1_latch_state, live0 & ~comp0_latch_state};
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      current_dac_value <= `CCR_RST_DAC;
      prox_override_q <= `CCR_RST_OVR;
      cap_sel_q <= `CCR_RST_CAP;
      in_sel_q <= `CCR_RST_IN_SEL;
      comp0_power_enable <= `CCR_RST_EN;
      comp1_power_enable <= `CCR_RST_EN;
      comp0_latch_state <= `CCR_RST_LATCH;
      comp1_latch_state <= `CCR_RST_LATCH;
      irq_stat_q <= `CCR_RST_IRQ;
      irq_mask_q <= `CCR_RST_IRQ;
      irq <= 1'h0;
    end
    else
    begin
      if (wr_dac)
        current_dac_value <= wbyte[`CCR_DAC_MSB:0];
      // reserved bits are simply not stored, so a careless write is harmless
      if (wr_bus_cfg)
      begin
        prox_override_q <= wbyte[`CCR_OVR_BIT];
        cap_sel_q <= wbyte[`CCR_CAP_MSB:`CCR_CAP_LSB];
      end
      if (wr_in_sel)
        in_sel_q <= wbyte;
      if (wr_enable)
      begin
        comp0_power_enable <= wbyte[`CCR_EN0_BIT];
        comp1_power_enable <= wbyte[`CCR_EN1_BIT];
      end
      comp0_latch_state <= latch0_d;
      comp1_latch_state <= latch1_d;
      irq_stat_q <= irq_stat_d;
      if (wr_irq_mask)
        irq_mask_q <= wbyte[1:0];
      // built from next status and mask so the line moves in step with them
      irq <= |(irq_stat_d & (wr_irq_mask ? wbyte[1:0] : irq_mask_q));
    end
  end

  // decoded analog controls, one cycle behind the register they follow
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      sense_clock_run <= 1'h0;
      cap_pin_first_en <= 1'h0;
      cap_pin_second_en <= 1'h0;
      comp0_pos_bus <= 1'h0;
      comp0_pos_pin_first <= 1'h0;
      comp0_pos_pin_second <= 1'h0;
      comp0_neg_vref <= 1'h0;
      comp0_neg_lo <= 1'h0;
      comp0_neg_hi <= 1'h0;
      comp1_pos_bus <= 1'h0;
      comp1_pos_pin_first <= 1'h0;
      comp1_pos_pin_second <= 1'h0;
      comp1_neg_vref <= 1'h0;
      comp1_neg_lo <= 1'h0;
      comp1_neg_hi <= 1'h0;
    end
    else
    begin
      sense_clock_run <= prox_override_q | sense_counter_enable;
      cap_pin_first_en <= cap_sel_q[0];
      cap_pin_second_en <= cap_sel_q[1];
      comp0_pos_bus <= p0_oh[0];
      comp0_pos_pin_first <= p0_oh[1];
      comp0_pos_pin_second <= p0_oh[2];
      comp0_neg_vref <= n0_oh[0];
      comp0_neg_lo <= n0_oh[1];
      comp0_neg_hi <= n0_oh[2];
      comp1_pos_bus <= p1_oh[0];
      comp1_pos_pin_first <= p1_oh[1];
      comp1_pos_pin_second <= p1_oh[2];
      comp1_neg_vref <= n1_oh[0];
      comp1_neg_lo <= n1_oh[1];
      comp1_neg_hi <= n1_oh[2];
    end
  end

  // read mux; unmapped indices and reserved bits read as zero
  always @*
  begin
    rd_byte = 8'h00;
    case (idx)
      `CCR_IDX_DAC: rd_byte = {1'h0, current_dac_value};
      `CCR_IDX_BUS_CFG:
      begin
        rd_byte[`CCR_OVR_BIT] = prox_override_q;
        rd_byte[`CCR_CAP_MSB:`CCR_CAP_LSB] = cap_sel_q;
      end
      `CCR_IDX_RD_CLR:
      begin
        rd_byte[`CCR_LIVE1_BIT] = live1;
        rd_byte[`CCR_LIVE0_BIT] = live0;
        rd_byte[`CCR_LATCH1_BIT] = comp1_latch_state;
        rd_byte[`CCR_LATCH0_BIT] = comp0_latch_state;
      end
      `CCR_IDX_IN_SEL: rd_byte = in_sel_q;
      `CCR_IDX_ENABLE:
      begin
        rd_byte[`CCR_EN1_BIT] = comp1_power_enable;
        rd_byte[`CCR_EN0_BIT] = comp0_power_enable;
      end
      `CCR_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
      `CCR_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // fixed two-cycle handshake: waitrequest drops for exactly one cycle
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'h1;
      avs_readdata <= 32'h00000000;
    end
    else if (avs_waitrequest)
    begin
      if (req)
      begin
        avs_waitrequest <= 1'h0;
        // captured when taken and then held, so it is steady while waitrequest is low
        avs_readdata <= avs_read ? {24'h000000, rd_byte} : 32'h00000000;
      end
    end
    else
    begin
      avs_waitrequest <= 1'h1;
    end
  end

endmodule // ccr_regs

// file: tb/ccr_comp_model.sv
// behavioural model of the two comparators and their logic-function outputs
module ccr_comp_model (
  input wire logic sys_clk,
  input wire logic [1:0] level,
  input wire logic [1:0] lf_level,
  output logic [1:0] raw = 2'h0,
  output logic [1:0] lf = 2'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // outputs keep following the inputs when powered off, so gating must be done by the bank
  always @(posedge sys_clk)
  begin
    raw <= level;
    lf <= lf_level;
  end
endmodule // ccr_comp_model

// file: tb/ccr_regs_assertions.sv
// port checker for the comparator control register bank
module ccr_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [6:0] current_dac_value,
  input wire logic sense_counter_enable,
  input wire logic sense_clock_run,
  input wire logic comp0_power_enable,
  input wire logic comp1_latch_reset_source,
  input wire logic comp0_latch_state,
  input wire logic comp1_latch_state,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer next cycle");
  chk_reset_zero: assert property (disable iff (1'b0) reset |=>
    current_dac_value == 7'h00 && !comp0_power_enable && !irq && avs_waitrequest)
    else $error("bad reset state");
  chk_dac_write: assert property (avs_write && !avs_waitrequest
    && avs_address[9:2] == 8'h31 && avs_byteenable[0]
    |=> current_dac_value == $past(avs_writedata[6:0]))
    else $error("dac code not written");
  chk_sense_enable: assert property (sense_counter_enable |=> sense_clock_run)
    else $error("sense clock gated while enabled");
  chk_live_gated: assert property (avs_read && !avs_waitrequest
    && avs_address[9:2] == 8'h78 && !comp0_power_enable |-> !avs_readdata[4])
    else $error("live bit of disabled comparator");
  chk_latch_clear: assert property ($fell(comp1_latch_state) |->
    $past(avs_write && !avs_waitrequest) || $past(comp1_latch_reset_source))
    else $error("latch dropped without cause");
  chk_irq_cause: assert property ($rose(irq) |-> $rose(comp0_latch_state)
    || $rose(comp1_latch_state) || $past(avs_write && !avs_waitrequest))
    else $error("interrupt without latch event");
endmodule // ccr_chk

bind ccr_regs ccr_chk u_ccr_chk (.*);

// file: tb/test_ccr_regs.sv
// self-checking testbench of the comparator control register bank
module test_ccr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, reset = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  logic sense_counter_enable = 1'h0;
  logic [9:0] avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] level = 2'h0, lf_level = 2'h0, raw, lf;
  logic comp0_latch_reset_source = 1'h0, comp1_latch_reset_source = 1'h0;
  logic avs_waitrequest, irq, sense_clock_run, cap_pin_first_en, cap_pin_second_en;
  logic comp0_raw, comp1_raw, comp0_logic_function_output, comp1_logic_function_output;
  logic [6:0] current_dac_value;
  logic comp0_pos_bus, comp0_pos_pin_first, comp0_pos_pin_second, comp0_neg_vref, comp0_neg_lo;
  logic comp0_neg_hi, comp1_pos_bus, comp1_pos_pin_first, comp1_pos_pin_second, comp1_neg_vref;
  logic comp1_neg_lo, comp1_neg_hi, comp0_power_enable, comp1_power_enable;
  logic comp0_latch_state, comp1_latch_state;
  logic [7:0] regs [7] = '{8'h31, 8'h61, 8'h78, 8'h79, 8'h7A, 8'h80, 8'h81};
  int error_cnt = 0, n_compared = 0, cyc = 0;
  wire [11:0] sel = {comp1_pos_pin_second, comp1_pos_pin_first, comp1_pos_bus, comp1_neg_hi,
    comp1_neg_lo, comp1_neg_vref, comp0_pos_pin_second, comp0_pos_pin_first, comp0_pos_bus,
    comp0_neg_hi, comp0_neg_lo, comp0_neg_vref};
  assign {comp1_raw, comp0_raw} = raw;
  assign {comp1_logic_function_output, comp0_logic_function_output} = lf;
  ccr_regs u_ccr_regs (.*);
  ccr_comp_model u_ccr_comp_model (.sys_clk(sys_clk), .level(level), .lf_level(lf_level),
    .raw(raw), .lf(lf));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("errors %0d of %0d compares", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hung handshake ends up here rather than stalling the run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // derived outputs trail the register by one edge, so sample just after it
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [2:0] pos(input logic [1:0] c);
    return c == 2'h0 ? 3'h1 : c == 2'h2 ? 3'h2 : c == 2'h3 ? 3'h4 : 3'h0;
  endfunction
  function automatic logic [2:0] neg(input logic [1:0] c);
    return c == 2'h3 ? 3'h0 : 3'h1 << c;
  endfunction
  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (regs[i]) rc(regs[i], 8'h00);
    wr(8'h31, 8'hFF);
    rc(8'h31, 8'h7F);
    chk(current_dac_value, 7'h7F);
    avs_byteenable <= 4'h0;
    wr(8'h31, 8'h05);
    avs_byteenable <= 4'hF;
    rc(8'h31, 8'h7F);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h61, {2'h0, i[0], 3'h0, i[1:0]});
      wt(1);
      chk({sense_clock_run, cap_pin_second_en, cap_pin_first_en}, {i[0], i[1:0]});
    end
    wr(8'h61, 8'h00);
    sense_counter_enable <= 1'b1;
    wt(2);
    chk(sense_clock_run, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h79, {i[1:0], ~i[1:0], ~i[1:0], i[1:0]});
      wt(1);
      chk(sel, {pos(i[1:0]), neg(~i[1:0]), pos(~i[1:0]), neg(i[1:0])});
    end
    rc(8'h79, 8'hC3);
    wr(8'h7A, 8'hFF);
    level <= 2'h3;
    rc(8'h7A, 8'h11);
    chk({comp1_power_enable, comp0_power_enable}, 2'h3);
    wt(6);
    rc(8'h78, 8'h33);
    chk({comp1_latch_state, comp0_latch_state}, 2'h3);
    level <= 2'h0;
    wt(6);
    wr(8'h78, 8'h33);
    rc(8'h78, 8'h03);
    rc(8'h80, 8'h03);
    chk(irq, 1'b0);
    wr(8'h81, 8'h01);
    wt(1);
    chk(irq, 1'b1);
    wr(8'h80, 8'h01);
    wt(1);
    chk(irq, 1'b0);
    rc(8'h80, 8'h02);
    rc(8'h81, 8'h01);
    rc(8'h40, 8'h00);
    wr(8'h78, 8'h00);
    rc(8'h78, 8'h00);
    wr(8'h7A, 8'h10);
    level <= 2'h3;
    wt(6);
    rc(8'h78, 8'h22);
    wr(8'h7A, 8'h11);
    wt(6);
    rc(8'h78, 8'h33);
    level <= 2'h0;
    comp0_latch_reset_source <= 1'b1;
    comp1_latch_reset_source <= 1'b1;
    wt(6);
    wr(8'h78, 8'h00);
    rc(8'h78, 8'h03);
    lf_level <= 2'h1;
    wt(6);
    rc(8'h78, 8'h01);
    chk({comp1_latch_state, comp0_latch_state}, 2'h1);
    lf_level <= 2'h3;
    wt(6);
    rc(8'h78, 8'h00);
    report_and_stop();
  end
endmodule // test_ccr_regs
